// >>> src/aapm_map.vh
`ifndef AAPM_MAP_VH
`define AAPM_MAP_VH

// Clock generator reference selection
`define AAPM_REF_W 2
`define AAPM_REF_MCLK 2'h0
`define AAPM_REF_BCLK 2'h1
`define AAPM_REF_DIN 2'h2
`define AAPM_REF_GPIO 2'h3

// Converter clock input selection
`define AAPM_CDC_W 2
`define AAPM_CDC_MCLK 2'h0
`define AAPM_CDC_BCLK 2'h1
`define AAPM_CDC_GPIO 2'h2
`define AAPM_CDC_PLL 2'h3

// Serial data input pin functions
`define AAPM_DIN_W 2
`define AAPM_DIN_AUDIO 2'h0
`define AAPM_DIN_GPI 2'h1
`define AAPM_DIN_CLK 2'h2

// General-purpose pin functions
`define AAPM_GPIO_W 4
`define AAPM_GPIO_OFF 4'h0
`define AAPM_GPIO_CLK 4'h1
`define AAPM_GPIO_GPI 4'h2
`define AAPM_GPIO_GPO 4'h3
`define AAPM_GPIO_FIRST_INTERRUPT_OUT 4'h4
`define AAPM_GPIO_SECOND_INTERRUPT_OUT 4'h5
`define AAPM_GPIO_SBCLK_IN 4'h6
`define AAPM_GPIO_SWCLK_IN 4'h7
`define AAPM_GPIO_SDIN 4'h8
`define AAPM_GPIO_SBCLK_OUT 4'h9
`define AAPM_GPIO_SWCLK_OUT 4'ha
`define AAPM_GPIO_AUXCLK 4'hb
`define AAPM_GPIO_DOUT 4'hc

// Control clock pin functions
`define AAPM_SCLK_W 3
`define AAPM_SCLK_CTRL 3'h0
`define AAPM_SCLK_GPI 3'h1
`define AAPM_SCLK_SBCLK_IN 3'h2
`define AAPM_SCLK_SWCLK_IN 3'h3
`define AAPM_SCLK_SDIN 3'h4

// Control data-out pin functions
`define AAPM_MISO_W 3
`define AAPM_MISO_CTRL 3'h0
`define AAPM_MISO_GPO 3'h1
`define AAPM_MISO_FIRST_INTERRUPT_OUT 3'h2
`define AAPM_MISO_SECOND_INTERRUPT_OUT 3'h3
`define AAPM_MISO_SBCLK_OUT 3'h4
`define AAPM_MISO_SWCLK_OUT 3'h5
`define AAPM_MISO_SDOUT 3'h6
`define AAPM_MISO_AUXCLK 3'h7

// Output enable polarity, active low
`define AAPM_OE_DRIVE 1'b0
`define AAPM_OE_RELEASE 1'b1

`endif

// >>> src/aapm_pin_drv.v
`timescale 1ns/1ps
`default_nettype none

`include "aapm_map.vh"

// One output-capable pin: a function code picks one source, so only one
// function can ever own the pin.
module aapm_pin_drv #(
    parameter FUNC_W = 3
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire [FUNC_W-1:0] func_i,
    input wire [(1<<FUNC_W)-1:0] src_i,
    input wire [(1<<FUNC_W)-1:0] drive_i,
    output wire pin_out_o,
    output wire pin_oe_n_o
);

    reg out_reg;
    reg oe_n_reg;

    always @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            out_reg <= 1'b0;
            oe_n_reg <= `AAPM_OE_RELEASE;
        end
        else
        begin
            // Data forced low while released to keep the wire quiet
            out_reg <= src_i[func_i] & drive_i[func_i];
            oe_n_reg <= drive_i[func_i] ? `AAPM_OE_DRIVE : `AAPM_OE_RELEASE;
        end
    end

    assign pin_out_o = out_reg;
    assign pin_oe_n_o = oe_n_reg;

endmodule // aapm_pin_drv

`default_nettype wire

// >>> src/aapm_pin_mux.v
// Notes on behaviour
// R1: The clock generator reference is chosen from the master clock, bit clock, serial data or general-purpose pin.
// R2: The master clock pin may feed the clock generator reference and the converter clock together.
// R3: The bit clock pin may feed the clock generator, converter clock and audio bit clock input together.
// R4: The general-purpose pin, set as clock input, may feed clock generator and converter clock together.
// R5: A pin given an exclusive function serves that function and nothing else.
// R6: The general-purpose pin never carries the first interrupt while it serves as general-purpose output.
// R7: First general-purpose output sits on the general-purpose pin, the second on control data-out.
// R8: Three general-purpose inputs come from serial data, general-purpose and control clock pins.
// R9: After reset master clock feeds the converter and bit clock, word clock and data serve the audio port.
// R10: Interrupts, secondary clock outputs and auxiliary clock go on general-purpose or control data-out pin.
`timescale 1ns/1ps
`default_nettype none

`include "aapm_map.vh"

module aapm_pin_mux (
    input wire ref_clk_i,
    input wire reset_i,
    // Configuration, taken on cfg_load_i
    input wire cfg_load_i,
    input wire [`AAPM_REF_W-1:0] cfg_ref_sel_i,
    input wire [`AAPM_CDC_W-1:0] cfg_cdc_sel_i,
    input wire cfg_bclk_master_i,
    input wire cfg_wclk_master_i,
    input wire [`AAPM_DIN_W-1:0] cfg_din_func_i,
    input wire [`AAPM_GPIO_W-1:0] cfg_gpio_func_i,
    input wire [`AAPM_SCLK_W-1:0] cfg_sclk_func_i,
    input wire [`AAPM_MISO_W-1:0] cfg_miso_func_i,
    // Pins
    input wire mclk_pin_i,
    input wire bclk_pin_i,
    output wire bclk_pin_o,
    output wire bclk_oe_n_o,
    input wire wclk_pin_i,
    output wire wclk_pin_o,
    output wire wclk_oe_n_o,
    input wire din_pin_i,
    input wire gpio_pin_i,
    output wire gpio_pin_o,
    output wire gpio_oe_n_o,
    input wire sclk_pin_i,
    output wire miso_pin_o,
    output wire miso_oe_n_o,
    // Internal sources
    input wire pll_clk_i,
    input wire asi_bclk_out_i,
    input wire asi_wclk_out_i,
    input wire asi_dout_i,
    input wire gpo1_i,
    input wire gpo2_i,
    input wire first_interrupt_out_i,
    input wire second_interrupt_out_i,
    input wire sec_bclk_out_i,
    input wire sec_wclk_out_i,
    input wire sec_dout_i,
    input wire aux_clk_i,
    input wire ctl_dout_i,
    input wire ctl_dout_en_i,
    // Internal destinations
    output wire pll_ref_o,
    output wire codec_clkin_o,
    output wire asi_bclk_o,
    output wire asi_wclk_o,
    output wire asi_din_o,
    output wire [2:0] gpi_o,
    output wire sec_bclk_o,
    output wire sec_wclk_o,
    output wire sec_din_o,
    output wire ctl_sclk_o
);

    // Active configuration
    reg [`AAPM_REF_W-1:0] ref_sel_reg;
    reg [`AAPM_CDC_W-1:0] cdc_sel_reg;
    reg bclk_master_reg;
    reg wclk_master_reg;
    reg [`AAPM_DIN_W-1:0] din_func_reg;
    reg [`AAPM_GPIO_W-1:0] gpio_func_reg;
    reg [`AAPM_SCLK_W-1:0] sclk_func_reg;
    reg [`AAPM_MISO_W-1:0] miso_func_reg;

    // Registered destinations
    reg pll_ref_reg, pll_ref_next;
    reg codec_clkin_reg, codec_clkin_next;
    reg asi_bclk_reg, asi_wclk_reg, asi_din_reg;
    reg [2:0] gpi_reg;
    reg sec_bclk_reg, sec_bclk_next;
    reg sec_wclk_reg, sec_wclk_next;
    reg sec_din_reg, sec_din_next;
    reg ctl_sclk_reg;
    reg bclk_out_reg, bclk_oe_n_reg;
    reg wclk_out_reg, wclk_oe_n_reg;

    wire bclk_free;
    wire gpio_clk;
    wire [15:0] gpio_src;
    wire [15:0] gpio_drv;
    wire [7:0] miso_src;
    wire [7:0] miso_drv;

    // R9 default allocation
    always @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            ref_sel_reg <= `AAPM_REF_MCLK;
            cdc_sel_reg <= `AAPM_CDC_MCLK;
            bclk_master_reg <= 1'b0;
            wclk_master_reg <= 1'b0;
            din_func_reg <= `AAPM_DIN_AUDIO;
            gpio_func_reg <= `AAPM_GPIO_OFF;
            sclk_func_reg <= `AAPM_SCLK_CTRL;
            miso_func_reg <= `AAPM_MISO_CTRL;
        end
        else if (cfg_load_i)
        begin
            ref_sel_reg <= cfg_ref_sel_i;
            cdc_sel_reg <= cfg_cdc_sel_i;
            bclk_master_reg <= cfg_bclk_master_i;
            wclk_master_reg <= cfg_wclk_master_i;
            din_func_reg <= cfg_din_func_i;
            gpio_func_reg <= cfg_gpio_func_i;
            sclk_func_reg <= cfg_sclk_func_i;
            miso_func_reg <= cfg_miso_func_i;
        end
    end

    // R5 bit clock output owns the pin, so it feeds no input
    assign bclk_free = ~bclk_master_reg;
    assign gpio_clk = (gpio_func_reg == `AAPM_GPIO_CLK);

    always @*
    begin
        // R1 reference from one of four pins
        case (ref_sel_reg)
            `AAPM_REF_MCLK: pll_ref_next = mclk_pin_i;
            `AAPM_REF_BCLK: pll_ref_next = bclk_pin_i & bclk_free;
            // R5 data pin lends itself only when given to the clock
            `AAPM_REF_DIN: pll_ref_next = din_pin_i & (din_func_reg == `AAPM_DIN_CLK);
            `AAPM_REF_GPIO: pll_ref_next = gpio_pin_i & gpio_clk;
            default: pll_ref_next = 1'b0;
        endcase
        // R2 R3 R4 converter clock chosen independently of reference
        case (cdc_sel_reg)
            `AAPM_CDC_MCLK: codec_clkin_next = mclk_pin_i;
            `AAPM_CDC_BCLK: codec_clkin_next = bclk_pin_i & bclk_free;
            `AAPM_CDC_GPIO: codec_clkin_next = gpio_pin_i & gpio_clk;
            `AAPM_CDC_PLL: codec_clkin_next = pll_clk_i;
            default: codec_clkin_next = 1'b0;
        endcase
        // Secondary inputs: general-purpose pin wins if both claim one
        sec_bclk_next = (gpio_func_reg == `AAPM_GPIO_SBCLK_IN) ? gpio_pin_i :
            (sclk_func_reg == `AAPM_SCLK_SBCLK_IN) & sclk_pin_i;
        sec_wclk_next = (gpio_func_reg == `AAPM_GPIO_SWCLK_IN) ? gpio_pin_i :
            (sclk_func_reg == `AAPM_SCLK_SWCLK_IN) & sclk_pin_i;
        sec_din_next = (gpio_func_reg == `AAPM_GPIO_SDIN) ? gpio_pin_i :
            (sclk_func_reg == `AAPM_SCLK_SDIN) & sclk_pin_i;
    end

    always @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            pll_ref_reg <= 1'b0;
            codec_clkin_reg <= 1'b0;
            asi_bclk_reg <= 1'b0;
            asi_wclk_reg <= 1'b0;
            asi_din_reg <= 1'b0;
            gpi_reg <= 3'h0;
            sec_bclk_reg <= 1'b0;
            sec_wclk_reg <= 1'b0;
            sec_din_reg <= 1'b0;
            ctl_sclk_reg <= 1'b0;
            bclk_out_reg <= 1'b0;
            bclk_oe_n_reg <= `AAPM_OE_RELEASE;
            wclk_out_reg <= 1'b0;
            wclk_oe_n_reg <= `AAPM_OE_RELEASE;
        end
        else
        begin
            pll_ref_reg <= pll_ref_next;
            codec_clkin_reg <= codec_clkin_next;
            // R3 bit clock also reaches the audio port
            asi_bclk_reg <= bclk_pin_i & bclk_free;
            // R5 word clock pin is input or output, never both
            asi_wclk_reg <= wclk_pin_i & ~wclk_master_reg;
            // R5 data pin serves audio only when so assigned
            asi_din_reg <= din_pin_i & (din_func_reg == `AAPM_DIN_AUDIO);
            // R8 three sampled general-purpose inputs
            gpi_reg[0] <= din_pin_i & (din_func_reg == `AAPM_DIN_GPI);
            gpi_reg[1] <= gpio_pin_i & (gpio_func_reg == `AAPM_GPIO_GPI);
            gpi_reg[2] <= sclk_pin_i & (sclk_func_reg == `AAPM_SCLK_GPI);
            sec_bclk_reg <= sec_bclk_next;
            sec_wclk_reg <= sec_wclk_next;
            sec_din_reg <= sec_din_next;
            ctl_sclk_reg <= sclk_pin_i & (sclk_func_reg == `AAPM_SCLK_CTRL);
            // R5 master outputs take the clock pins exclusively
            bclk_out_reg <= asi_bclk_out_i & bclk_master_reg;
            bclk_oe_n_reg <= bclk_master_reg ? `AAPM_OE_DRIVE : `AAPM_OE_RELEASE;
            wclk_out_reg <= asi_wclk_out_i & wclk_master_reg;
            wclk_oe_n_reg <= wclk_master_reg ? `AAPM_OE_DRIVE : `AAPM_OE_RELEASE;
        end
    end

    // R6 one code per pin keeps output and first interrupt apart
    // R7 R10 output functions of the general-purpose pin
    assign gpio_src = {3'h0, asi_dout_i, aux_clk_i, sec_wclk_out_i, sec_bclk_out_i,
        3'h0, second_interrupt_out_i, first_interrupt_out_i, gpo1_i, 3'h0};
    assign gpio_drv = 16'h1e38;

    // R7 R10 output functions of the control data-out pin
    assign miso_src = {aux_clk_i, sec_dout_i, sec_wclk_out_i, sec_bclk_out_i,
        second_interrupt_out_i, first_interrupt_out_i, gpo2_i, ctl_dout_i};
    // Control read data releases the pin between transfers
    assign miso_drv = {7'h7f, ctl_dout_en_i};

    aapm_pin_drv #(
        .FUNC_W(`AAPM_GPIO_W)
    ) u_gpio_drv (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .func_i(gpio_func_reg),
        .src_i(gpio_src),
        .drive_i(gpio_drv),
        .pin_out_o(gpio_pin_o),
        .pin_oe_n_o(gpio_oe_n_o)
    );

    aapm_pin_drv #(
        .FUNC_W(`AAPM_MISO_W)
    ) u_miso_drv (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .func_i(miso_func_reg),
        .src_i(miso_src),
        .drive_i(miso_drv),
        .pin_out_o(miso_pin_o),
        .pin_oe_n_o(miso_oe_n_o)
    );

    assign pll_ref_o = pll_ref_reg;
    assign codec_clkin_o = codec_clkin_reg;
    assign asi_bclk_o = asi_bclk_reg;
    assign asi_wclk_o = asi_wclk_reg;
    assign asi_din_o = asi_din_reg;
    assign gpi_o = gpi_reg;
    assign sec_bclk_o = sec_bclk_reg;
    assign sec_wclk_o = sec_wclk_reg;
    assign sec_din_o = sec_din_reg;
    assign ctl_sclk_o = ctl_sclk_reg;
    assign bclk_pin_o = bclk_out_reg;
    assign bclk_oe_n_o = bclk_oe_n_reg;
    assign wclk_pin_o = wclk_out_reg;
    assign wclk_oe_n_o = wclk_oe_n_reg;

endmodule // aapm_pin_mux

`default_nettype wire

// >>> test/aapm_far_end.sv
`timescale 1ns/1ps
`default_nettype none

module aapm_far_end (
    input wire logic ref_clk_i,
    output logic [5:0] pins_o
);
    logic [3:0] cnt_reg = 4'h0;

    always @(posedge ref_clk_i)
        cnt_reg <= #1 cnt_reg + 4'h1;

    // Distinct waveforms per pin, so a crossed route cannot match by chance
    assign pins_o = {cnt_reg[0], cnt_reg[1], ~cnt_reg[0], cnt_reg[2], cnt_reg[1] ^ cnt_reg[0], cnt_reg[3]};
endmodule // aapm_far_end

`default_nettype wire

// >>> test/aapm_pin_mux_sva.sv
`timescale 1ns/1ps
`default_nettype none

`include "aapm_map.vh"

module aapm_pin_mux_chk (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic cfg_load_i,
    input wire logic [1:0] cfg_ref_sel_i,
    input wire logic [1:0] cfg_cdc_sel_i,
    input wire logic cfg_bclk_master_i,
    input wire logic [1:0] cfg_din_func_i,
    input wire logic [3:0] cfg_gpio_func_i,
    input wire logic [2:0] cfg_miso_func_i,
    input wire logic mclk_pin_i,
    input wire logic bclk_pin_i,
    input wire logic din_pin_i,
    input wire logic gpio_pin_i,
    input wire logic gpio_pin_o,
    input wire logic gpio_oe_n_o,
    input wire logic miso_pin_o,
    input wire logic miso_oe_n_o,
    input wire logic gpo1_i,
    input wire logic gpo2_i,
    input wire logic first_interrupt_out_i,
    input wire logic pll_ref_o,
    input wire logic codec_clkin_o,
    input wire logic asi_bclk_o,
    input wire logic asi_din_o,
    input wire logic [2:0] gpi_o
);
    logic [1:0] ref_reg, cdc_reg, din_reg;
    logic [3:0] gpio_reg;
    logic [2:0] miso_reg;
    logic bm_reg;

    // Mirror of the active configuration; all defaults are code zero
    always @(posedge ref_clk_i)
    begin
        if (reset_i)
            {ref_reg, cdc_reg, din_reg, gpio_reg, miso_reg, bm_reg} <= 14'h0;
        else if (cfg_load_i)
            {ref_reg, cdc_reg, din_reg, gpio_reg, miso_reg, bm_reg} <= {cfg_ref_sel_i, cfg_cdc_sel_i,
                cfg_din_func_i, cfg_gpio_func_i, cfg_miso_func_i, cfg_bclk_master_i};
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence gpo_load_s;
        cfg_load_i && cfg_gpio_func_i == `AAPM_GPIO_GPO ##1 !cfg_load_i [*2];
    endsequence

    gpo_walk_a: assert property (gpo_load_s |=> !gpio_oe_n_o)
        else $error("gpio pin idle after output load");
    mclk_both_a: assert property (ref_reg == `AAPM_REF_MCLK && cdc_reg == `AAPM_CDC_MCLK |=>
        pll_ref_o == $past(mclk_pin_i) && codec_clkin_o == $past(mclk_pin_i)) else $error("mclk fan-out wrong");
    bclk_three_a: assert property (ref_reg == `AAPM_REF_BCLK && cdc_reg == `AAPM_CDC_BCLK && !bm_reg |=>
        pll_ref_o == $past(bclk_pin_i) && codec_clkin_o == $past(bclk_pin_i) && asi_bclk_o == $past(bclk_pin_i))
        else $error("bclk fan-out wrong");
    gpio_clk_a: assert property (gpio_reg == `AAPM_GPIO_CLK && ref_reg == `AAPM_REF_GPIO &&
        cdc_reg == `AAPM_CDC_GPIO |=> pll_ref_o == $past(gpio_pin_i) && codec_clkin_o == $past(gpio_pin_i))
        else $error("gpio clock fan-out wrong");
    din_ref_a: assert property (ref_reg == `AAPM_REF_DIN && din_reg == `AAPM_DIN_CLK |=>
        pll_ref_o == $past(din_pin_i)) else $error("din reference wrong");
    gpo_only_a: assert property (gpio_reg == `AAPM_GPIO_GPO |=>
        !gpio_oe_n_o && gpio_pin_o == $past(gpo1_i)) else $error("gpio output not gpo1");
    miso_gpo_a: assert property (miso_reg == `AAPM_MISO_GPO |=>
        !miso_oe_n_o && miso_pin_o == $past(gpo2_i)) else $error("miso output not gpo2");
    din_gpi_a: assert property (din_reg == `AAPM_DIN_GPI |=> gpi_o[0] == $past(din_pin_i))
        else $error("gpi0 not from din");
    din_excl_a: assert property (din_reg != `AAPM_DIN_AUDIO |=> !asi_din_o)
        else $error("audio data leaks from reused din");
    din_audio_a: assert property (din_reg == `AAPM_DIN_AUDIO |=> asi_din_o == $past(din_pin_i))
        else $error("audio data not from din");
    miso_int_a: assert property (miso_reg == `AAPM_MISO_FIRST_INTERRUPT_OUT |=>
        !miso_oe_n_o && miso_pin_o == $past(first_interrupt_out_i)) else $error("interrupt not on miso");
endmodule // aapm_pin_mux_chk

bind aapm_pin_mux aapm_pin_mux_chk aapm_pin_mux_chk_i (.*);

`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic ref_clk_i = 1'b0, reset_i = 1'b1, cfg_load_i = 1'b0;
    logic [1:0] cfg_ref_sel_i = 2'h0, cfg_cdc_sel_i = 2'h0, cfg_din_func_i = 2'h0;
    logic [3:0] cfg_gpio_func_i = 4'h0;
    logic [2:0] cfg_sclk_func_i = 3'h0, cfg_miso_func_i = 3'h0;
    logic cfg_bclk_master_i = 1'b0, cfg_wclk_master_i = 1'b0;
    logic mclk_pin_i, bclk_pin_i, wclk_pin_i, din_pin_i, gpio_pin_i, sclk_pin_i;
    logic pll_clk_i, asi_bclk_out_i, asi_wclk_out_i, asi_dout_i, gpo1_i, gpo2_i, first_interrupt_out_i;
    logic second_interrupt_out_i, sec_bclk_out_i, sec_wclk_out_i, sec_dout_i, aux_clk_i, ctl_dout_i, ctl_dout_en_i;
    wire logic bclk_pin_o, bclk_oe_n_o, wclk_pin_o, wclk_oe_n_o, gpio_pin_o, gpio_oe_n_o, miso_pin_o, miso_oe_n_o;
    wire logic pll_ref_o, codec_clkin_o, asi_bclk_o, asi_wclk_o, asi_din_o, sec_bclk_o, sec_wclk_o, sec_din_o;
    wire logic ctl_sclk_o;
    wire logic [2:0] gpi_o;
    logic [5:0] far, pp;
    logic [13:0] src_reg = 14'h0, ps;
    int miscompares = 0, num_checks = 0;

    aapm_far_end aapm_far_end_i (.ref_clk_i(ref_clk_i), .pins_o(far));
    aapm_pin_mux aapm_pin_mux_i (.*);

    assign {mclk_pin_i, bclk_pin_i, wclk_pin_i, din_pin_i, sclk_pin_i} = {far[5:2], far[0]};
    // Shared wire: the far side yields while the device drives
    assign gpio_pin_i = gpio_oe_n_o ? far[1] : gpio_pin_o;
    assign {pll_clk_i, asi_bclk_out_i, asi_wclk_out_i, asi_dout_i, gpo1_i, gpo2_i, first_interrupt_out_i,
        second_interrupt_out_i, sec_bclk_out_i, sec_wclk_out_i, sec_dout_i, aux_clk_i, ctl_dout_i,
        ctl_dout_en_i} = src_reg;

    always #12.5 ref_clk_i = ~ref_clk_i;

    always @(posedge ref_clk_i)
        src_reg <= #1 {src_reg[12:0], ~(src_reg[13] ^ src_reg[4])};

    // Pin and source levels seen at each edge, for the one-edge latency
    always @(posedge ref_clk_i)
    begin
        pp <= {mclk_pin_i, bclk_pin_i, wclk_pin_i, din_pin_i, gpio_pin_i, sclk_pin_i};
        ps <= src_reg;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic load(input logic [1:0] r, c, d, input logic [3:0] g, input logic [2:0] s, m);
        @(posedge ref_clk_i);
        #1;
        {cfg_ref_sel_i, cfg_cdc_sel_i, cfg_din_func_i, cfg_gpio_func_i, cfg_sclk_func_i, cfg_miso_func_i} =
            {r, c, d, g, s, m};
        cfg_load_i = 1'b1;
        @(posedge ref_clk_i);
        #1;
        cfg_load_i = 1'b0;
        repeat (2) @(posedge ref_clk_i);
    endtask

    task automatic tick;
        @(posedge ref_clk_i);
        #2;
    endtask

    task automatic t_default;
        repeat (8)
        begin
            tick;
            chk(codec_clkin_o, pp[5]);
            chk({asi_bclk_o, asi_wclk_o, asi_din_o}, pp[4:2]);
            chk({gpio_oe_n_o, bclk_oe_n_o, wclk_oe_n_o}, 3'h7);
            chk({ctl_sclk_o, miso_oe_n_o, miso_pin_o}, {pp[0], ~ps[0], ps[1] & ps[0]});
        end
        $display("default routing test done");
    endtask

    task automatic t_clock_src;
        logic [15:0] pin = 16'h1245;
        logic [7:0] cdc = 8'h84;
        for (int i = 0; i < 4; i++)
        begin
            load(i[1:0], cdc[2*i+:2], 2'h2, 4'h1, 3'h0, 3'h0);
            repeat (8)
            begin
                tick;
                chk(pll_ref_o, pp[pin[4*i+:4]]);
                chk(codec_clkin_o, pp[i == 2 ? 5 : pin[4*i+:4]]);
                chk({asi_bclk_o, asi_din_o}, {pp[4], 1'b0});
            end
        end
        $display("clock source test done");
    endtask

    task automatic t_outputs;
        logic [23:0] g = 24'hcba954;
        logic [23:0] gb = 24'ha24567;
        load(2'h0, 2'h0, 2'h0, 4'h3, 3'h0, 3'h1);
        repeat (8)
        begin
            tick;
            chk({gpio_oe_n_o, gpio_pin_o}, {1'b0, ps[9]});
            chk({miso_oe_n_o, miso_pin_o}, {1'b0, ps[8]});
        end
        for (int i = 0; i < 6; i++)
        begin
            load(2'h0, 2'h0, 2'h0, g[4*i+:4], 3'h0, 3'(i + 2));
            repeat (8)
            begin
                tick;
                chk({gpio_oe_n_o, gpio_pin_o}, {1'b0, ps[gb[4*i+:4]]});
                chk({miso_oe_n_o, miso_pin_o}, {1'b0, ps[7 - i]});
            end
        end
        $display("pin output test done");
    endtask

    task automatic t_inputs;
        load(2'h2, 2'h0, 2'h1, 4'h2, 3'h1, 3'h0);
        repeat (8)
        begin
            tick;
            chk(gpi_o, {pp[0], pp[1], pp[2]});
            chk({asi_din_o, pll_ref_o, ctl_sclk_o}, 3'h0);
        end
        $display("general input test done");
    endtask

    task automatic t_master;
        @(posedge ref_clk_i);
        #1;
        {cfg_bclk_master_i, cfg_wclk_master_i} = 2'h3;
        for (int i = 0; i < 2; i++)
        begin
            load(2'(1 - i), 2'h3, 2'h0, 4'(6 + 2 * i), 3'(3 - i), 3'h0);
            repeat (8)
            begin
                tick;
                chk({bclk_oe_n_o, bclk_pin_o, wclk_oe_n_o, wclk_pin_o}, {1'b0, ps[12], 1'b0, ps[11]});
                chk({asi_bclk_o, asi_wclk_o, ctl_sclk_o}, 3'h0);
                chk(pll_ref_o, i == 0 ? 1'b0 : pp[5]);
                chk(codec_clkin_o, ps[13]);
                chk({sec_bclk_o, sec_wclk_o, sec_din_o}, i == 0 ? {pp[1], pp[0], 1'b0} : {pp[0], 1'b0, pp[1]});
            end
        end
        $display("clock master test done");
    endtask

    task automatic t_reset;
        @(posedge ref_clk_i);
        #1;
        reset_i = 1'b1;
        tick;
        chk({bclk_oe_n_o, wclk_oe_n_o, gpio_oe_n_o, miso_oe_n_o}, 4'hf);
        chk({bclk_pin_o, wclk_pin_o, gpio_pin_o, miso_pin_o, pll_ref_o, codec_clkin_o, sec_bclk_o, gpi_o}, 10'h0);
        @(posedge ref_clk_i);
        #1;
        reset_i = 1'b0;
        $display("mid-run reset test done");
    endtask

    task automatic give_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge ref_clk_i);
        #1;
        reset_i = 1'b0;
        t_default;
        t_clock_src;
        t_outputs;
        t_inputs;
        t_master;
        t_reset;
        t_default;
        give_verdict;
    end
endmodule // tb_top

`default_nettype wire
